// File: inc/aisf_pkg.sv
package aisf_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_CTRL      = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] ADDR_BUF_STATE = 8'h10;
    // Status bit positions
    localparam int unsigned BIT_DRDY   = 7;
    localparam int unsigned BIT_OVF    = 6;
    localparam int unsigned BIT_BUF    = 5;
    localparam int unsigned BIT_OT     = 4;
    localparam int unsigned BIT_WT     = 3;
    localparam int unsigned BIT_ORIENTATION_DETECTION = 2;
    localparam int unsigned BIT_ASLP   = 1;
    localparam int unsigned BIT_BOOT   = 0;
    localparam logic [7:0]  STATUS_RST = 8'h01;
    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_LATCH    = 2;
    localparam int unsigned CTRL_DRDY_SEL = 3;
    localparam int unsigned CTRL_BUF_EN   = 4;
    localparam int unsigned CTRL_BUF_SEL  = 5;
    localparam int unsigned CTRL_W        = 6;
    localparam logic [5:0]  CTRL_RST      = 6'h00;
    localparam logic [7:0]  MASK_RST      = 8'h00;
    // Buffer modes
    localparam logic [1:0]  BUF_MODE_OFF  = 2'h0;
    localparam logic [1:0]  BUF_MODE_TRIG = 2'h2;
    // Motion pulse time
    localparam int unsigned MOTION_PULSE_MS = 5;
    localparam int unsigned CLK_KHZ         = 100000;
    localparam int unsigned PULSE_CYCLES    = MOTION_PULSE_MS * CLK_KHZ;
    // Pulse timer states
    typedef enum logic [0:0] {
        AISF_PT_IDLE = 1'b0,
        AISF_PT_RUN  = 1'b1
    } aisf_pt_state_t;
endpackage : aisf_pkg

// File: core/aisf_sticky_w1c.sv
`timescale 1ns/10ps
module aisf_sticky_w1c #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    // Events and clears
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    // Flags
    output logic      [W-1:0] flags_o
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    // Per bit, a set in the clearing cycle wins
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            flags_d[i] = set_i[i] | (flags_q[i] & ~clr_i[i]);
        end
    end

    // Flag register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
endmodule : aisf_sticky_w1c

// File: core/aisf_pulse_timer.sv
`timescale 1ns/10ps
module aisf_pulse_timer #(
    parameter int unsigned CYCLES = aisf_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    // Control
    input  wire logic start_i,
    input  wire logic abort_i,
    // Pulse
    output logic      pulse_o
);
    import aisf_pkg::*;

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    aisf_pt_state_t state_q;
    aisf_pt_state_t state_d;
    logic [CW-1:0]  cnt_q;
    logic [CW-1:0]  cnt_d;

    // Next state: abort wins, a start restarts the count
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            AISF_PT_IDLE: begin
                if (start_i && !abort_i) begin
                    state_d = AISF_PT_RUN;
                    cnt_d   = LAST;
                end
            end
            AISF_PT_RUN: begin
                if (abort_i) begin
                    state_d = AISF_PT_IDLE;
                end else if (start_i) begin
                    cnt_d = LAST;
                end else if (cnt_q == '0) begin
                    state_d = AISF_PT_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: state_d = AISF_PT_IDLE;
        endcase
    end

    // State and count registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= AISF_PT_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign pulse_o = (state_q == AISF_PT_RUN);
endmodule : aisf_pulse_timer

// File: core/aisf_status_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module aisf_status_top #(
    parameter int unsigned PULSE_CYCLES = aisf_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    // APB slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Result path events
    input  wire logic         sample_set_i,
    input  wire logic         axis_read_i,
    input  wire logic         aux_read_i,
    input  wire logic         active_entry_i,
    input  wire logic         motion_detect_mode_pin_i,
    // Output buffer state
    input  wire logic         buffer_watermark_flag_i,
    input  wire logic         buffer_overflow_flag_i,
    input  wire logic         buffer_gate_err_i,
    input  wire logic         buffer_full_i,
    // Other event sources
    input  wire logic         outside_event_active_i,
    input  wire logic         outside_limits_source_read_i,
    input  wire logic         inside_limits_flag_i,
    input  wire logic         orientation_change_flag_i,
    input  wire logic         auto_sleep_flag_i,
    // Interrupt outputs
    output logic              irq_pin_one_o,
    output logic              irq_pin_two_o,
    output logic              irq_o
);
    import aisf_pkg::*;

    // Status flags
    logic              drdy_q, drdy_d;
    logic              ovf_q, ovf_d;
    logic              bufev_q, bufev_d;
    logic              ot_q, ot_d;
    logic              wt_q, wt_d;
    logic              orientation_detection_q, orientation_detection_d;
    logic              aslp_q, aslp_d;
    logic              boot_q, boot_d;
    logic              unread_q, unread_d;
    logic [7:0]        status;
    logic [7:0]        status_d;
    // Software registers
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [7:0]        mask_q, mask_d;
    logic [31:0]       prdata_q, prdata_d;
    logic [7:0]        irq_flags;
    logic [7:0]        irq_clr;
    // Pins
    logic              pin_one_q, pin_one_d;
    logic              pin_two_q, pin_two_d;
    // Decoded terms
    logic [1:0]        buf_mode;
    logic              buf_on;
    logic              latch_en;
    logic              apb_setup;
    logic              apb_acc;
    logic              addr_hit;
    logic              stat_rd;
    logic              out_read;
    logic              ovf_set;
    logic              buf_evt;
    logic              drdy_pulse;
    logic              drdy_irq;

    // Control field decode
    assign buf_mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign buf_on   = (buf_mode != BUF_MODE_OFF);
    assign latch_en = ctrl_q[CTRL_LATCH];

    // APB phases; the slave never inserts wait states
    assign apb_setup = psel_i & ~penable_i;
    assign apb_acc   = psel_i & penable_i;
    assign pready_o  = 1'b1;

    // Address decode
    always_comb begin
        if (paddr_i == ADDR_STATUS) begin
            addr_hit = 1'b1;
        end else if (paddr_i == ADDR_CTRL) begin
            addr_hit = 1'b1;
        end else if (paddr_i == ADDR_IRQ_STAT) begin
            addr_hit = 1'b1;
        end else if (paddr_i == ADDR_IRQ_MASK) begin
            addr_hit = 1'b1;
        end else if (paddr_i == ADDR_BUF_STATE) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // Unmapped addresses answer with an error
    assign pslverr_o = apb_acc & ~addr_hit;

    // Read side effect of the status register
    assign stat_rd  = apb_acc & ~pwrite_i & (paddr_i == ADDR_STATUS);
    assign out_read = axis_read_i | aux_read_i;

    // Overwrite of a set with no axis read in between
    assign ovf_set = sample_set_i & unread_q & ~axis_read_i;

    // Buffer event sources; watermark left out in triggered mode
    assign buf_evt = buf_on & (
                     (buffer_watermark_flag_i & (buf_mode != BUF_MODE_TRIG))
                     | buffer_overflow_flag_i
                     | buffer_gate_err_i
                     | buffer_full_i);

    // Status flag next values
    always_comb begin
        // New set waits for an axis read
        unread_d = sample_set_i | (unread_q & ~axis_read_i);
        // Sample ready: set wins over a read in the same cycle
        if (buf_on) begin
            drdy_d = 1'b0;
        end else begin
            drdy_d = sample_set_i | (drdy_q & ~out_read);
        end
        // Overrun: only bits the host actually saw are cleared
        if (buf_on) begin
            ovf_d = 1'b0;
        end else begin
            ovf_d = ovf_set | (ovf_q & ~(stat_rd & prdata_q[BIT_OVF]));
        end
        bufev_d = buf_evt;
        // Outside flag latched until its source register is read
        if (latch_en) begin
            ot_d = outside_event_active_i | (ot_q & ~outside_limits_source_read_i);
        end else begin
            ot_d = outside_event_active_i;
        end
        wt_d     = inside_limits_flag_i;
        orientation_detection_d = orientation_change_flag_i;
        aslp_d   = auto_sleep_flag_i;
        // Boot flag cleared once the host has seen it
        boot_d   = boot_q & ~(stat_rd & prdata_q[BIT_BOOT]);
    end

    // Status flag registers, read-only to software
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            unread_q <= 1'b0;
            drdy_q   <= STATUS_RST[BIT_DRDY];
            ovf_q    <= STATUS_RST[BIT_OVF];
            bufev_q  <= STATUS_RST[BIT_BUF];
            ot_q     <= STATUS_RST[BIT_OT];
            wt_q     <= STATUS_RST[BIT_WT];
            orientation_detection_q <= STATUS_RST[BIT_ORIENTATION_DETECTION];
            aslp_q   <= STATUS_RST[BIT_ASLP];
            boot_q   <= STATUS_RST[BIT_BOOT];
        end else begin
            unread_q <= unread_d;
            drdy_q   <= drdy_d;
            ovf_q    <= ovf_d;
            bufev_q  <= bufev_d;
            ot_q     <= ot_d;
            wt_q     <= wt_d;
            orientation_detection_q <= orientation_detection_d;
            aslp_q   <= aslp_d;
            boot_q   <= boot_d;
        end
    end

    // Packed views of the status byte
    assign status   = {drdy_q, ovf_q, bufev_q, ot_q, wt_q, orientation_detection_q, aslp_q, boot_q};
    assign status_d = {drdy_d, ovf_d, bufev_d, ot_d, wt_d, orientation_detection_d, aslp_d, boot_d};

    // Data-ready pulse for the motion-detect pin mode
    aisf_pulse_timer #(
        .CYCLES     (PULSE_CYCLES)
    ) u_pulse (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .start_i    (sample_set_i & ~buf_on & motion_detect_mode_pin_i),
        .abort_i    (active_entry_i),
        .pulse_o    (drdy_pulse)
    );

    // Pin level follows the flag, or the pulse when the pin is high
    assign drdy_irq = motion_detect_mode_pin_i ? drdy_pulse : drdy_q;

    // Software register next values
    always_comb begin
        ctrl_d   = ctrl_q;
        mask_d   = mask_q;
        prdata_d = prdata_q;
        // Writes take effect in the access phase
        if (apb_acc && pwrite_i) begin
            if (paddr_i == ADDR_CTRL) begin
                ctrl_d = pwdata_i[CTRL_W-1:0];
            end else if (paddr_i == ADDR_IRQ_MASK) begin
                mask_d = pwdata_i[7:0];
            end
        end
        // Read data is captured in the setup phase
        if (apb_setup && !pwrite_i) begin
            if (paddr_i == ADDR_STATUS) begin
                prdata_d = {24'h000000, status};
            end else if (paddr_i == ADDR_CTRL) begin
                prdata_d = {26'h0000000, ctrl_q};
            end else if (paddr_i == ADDR_IRQ_STAT) begin
                prdata_d = {24'h000000, irq_flags};
            end else if (paddr_i == ADDR_IRQ_MASK) begin
                prdata_d = {24'h000000, mask_q};
            end else if (paddr_i == ADDR_BUF_STATE) begin
                prdata_d = {29'h00000000, buffer_gate_err_i,
                            buffer_overflow_flag_i, buffer_watermark_flag_i};
            end else begin
                prdata_d = 32'h00000000;
            end
        end
    end

    // Software registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ctrl_q   <= CTRL_RST;
            mask_q   <= MASK_RST;
            prdata_q <= 32'h00000000;
        end else begin
            ctrl_q   <= ctrl_d;
            mask_q   <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata_o = prdata_q;

    // Write-one-to-clear of the interrupt status
    assign irq_clr = (apb_acc && pwrite_i && paddr_i == ADDR_IRQ_STAT) ? pwdata_i[7:0] : 8'h00;

    // Every rising status flag is a sticky interrupt event
    aisf_sticky_w1c #(
        .W          (8)
    ) u_irq (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (status_d & ~status),
        .clr_i      (irq_clr),
        .flags_o    (irq_flags)
    );

    assign irq_o = |(irq_flags & mask_q);

    // Pin routing of data-ready and buffer events
    always_comb begin
        pin_one_d = (drdy_irq & ~ctrl_q[CTRL_DRDY_SEL])
                  | (bufev_q & ctrl_q[CTRL_BUF_EN] & ~ctrl_q[CTRL_BUF_SEL]);
        pin_two_d = (drdy_irq & ctrl_q[CTRL_DRDY_SEL])
                  | (bufev_q & ctrl_q[CTRL_BUF_EN] & ctrl_q[CTRL_BUF_SEL]);
    end

    // Pin registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_one_q <= 1'b0;
            pin_two_q <= 1'b0;
        end else begin
            pin_one_q <= pin_one_d;
            pin_two_q <= pin_two_d;
        end
    end

    assign irq_pin_one_o = pin_one_q;
    assign irq_pin_two_o = pin_two_q;

    // Checks on the flag behaviour
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    // New set raises sample ready
    a_drdy_set_new: assert property (sample_set_i && !buf_on |=> drdy_q)
        else $error("sample ready not set by new set");

    // Output read drops sample ready
    a_drdy_read_clr: assert property (
        drdy_q && out_read && !sample_set_i |=> !drdy_q)
        else $error("sample ready not cleared by read");

    // Buffer mode holds sample ready low
    a_drdy_buf_hold: assert property (buf_on |=> !drdy_q)
        else $error("sample ready high with buffer on");

    // Pin low mode: pin follows flag one cycle on
    a_pin_level_mode: assert property (
        !motion_detect_mode_pin_i && !ctrl_q[CTRL_DRDY_SEL] && !ctrl_q[CTRL_BUF_EN]
        ##1 !motion_detect_mode_pin_i && $stable(ctrl_q)
        |=> irq_pin_one_o == $past(drdy_q))
        else $error("pin level does not follow flag");

    // Pin high mode: a set starts the pulse
    a_pulse_start: assert property (
        motion_detect_mode_pin_i && sample_set_i && !buf_on && !active_entry_i
        |=> drdy_pulse [*1] ##0 (u_pulse.cnt_q == (PULSE_CYCLES - 1)))
        else $error("data-ready pulse not started");

    // Active entry ends the pulse at once
    a_pulse_abort: assert property (active_entry_i |=> !drdy_pulse)
        else $error("pulse not cut by active entry");

    // Overwritten set raises overrun
    a_ovf_set: assert property (ovf_set && !buf_on |=> ovf_q)
        else $error("overrun not set");

    // An axis read in between blocks overrun
    a_ovf_blocked: assert property (
        !ovf_q && axis_read_i ##1 !ovf_q && sample_set_i && !unread_q |=> !ovf_q)
        else $error("overrun set after axis read");

    // Status read clears overrun
    a_ovf_read_clr: assert property (
        stat_rd && prdata_q[BIT_OVF] && !ovf_set |=> !ovf_q)
        else $error("overrun not cleared by status read");

    // Buffer mode holds overrun low
    a_ovf_buf_hold: assert property (buf_on |=> !ovf_q)
        else $error("overrun high with buffer on");

    // Overflow or gate error raises the buffer event
    a_bufev_or: assert property (
        buf_on && (buffer_overflow_flag_i || buffer_gate_err_i) |=> bufev_q)
        else $error("buffer event missing");

    // No buffer event with buffer off
    a_bufev_off: assert property (!buf_on |=> !bufev_q)
        else $error("buffer event with buffer off");

    // Triggered mode ignores the watermark
    a_trig_wmrk: assert property (
        buf_mode == BUF_MODE_TRIG && !buffer_overflow_flag_i && !buffer_gate_err_i
        && !buffer_full_i |=> !bufev_q)
        else $error("watermark leaked into buffer event");

    // Full buffer reaches the chosen pin
    a_full_pin: assert property (
        buffer_full_i && buf_on && ctrl_q[CTRL_BUF_EN] && !ctrl_q[CTRL_BUF_SEL]
        ##1 $stable(ctrl_q) |=> irq_pin_one_o)
        else $error("buffer full not on pin");

    // Unlatched outside flag mirrors its source
    a_ot_mirror: assert property (!latch_en |=> ot_q == $past(outside_event_active_i))
        else $error("outside flag not mirroring");

    // Reset leaves only the boot flag set
    a_reset_value: assert property (
        disable iff (1'b0) srst_i |=> status == STATUS_RST)
        else $error("status reset value wrong");

    // Main scenarios
    c_pulse_cut: cover property (drdy_pulse && active_entry_i);
    c_ovf_read: cover property (ovf_q ##[1:20] stat_rd);
    c_buf_full_pin: cover property (buffer_full_i && buf_on ##2 irq_pin_two_o);
endmodule : aisf_status_top

// File: testbench/aisf_host_model.sv
`timescale 1ns/10ps
// Host side: APB master that reaches the status registers
module aisf_host_model (
    // Clock
    input  wire logic        core_clk_i,
    // APB master
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o,
    input  wire logic        pready_i
);
    // Bus idle at time zero
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0;
    end

    // One transfer; the request is held until pready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_o   <= 1'b1;
        pwrite_o <= wr;
        paddr_o  <= a;
        pwdata_o <= d;
        @(posedge core_clk_i);
        penable_o <= 1'b1;
        @(posedge core_clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge core_clk_i);
        end
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
    endtask : bus
endmodule : aisf_host_model

// File: testbench/test_accel_interrupt_status_flags.sv
`timescale 1ns/10ps
module test_accel_interrupt_status_flags;
    import aisf_pkg::*;
    localparam int unsigned PC = 20;
    logic        core_clk_i;
    logic        srst_i;
    logic        psel, penable, pwrite, pready, pslverr, pin1, pin2, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [4:0]  ev_q;
    logic [8:0]  lv_q;
    logic [32:0] exp_q[$];
    logic [31:0] rm;
    int          bad_count, comparisons, n;

    aisf_status_top #(.PULSE_CYCLES(PC)) aisf_status_top_i (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sample_set_i(ev_q[0]),
        .axis_read_i(ev_q[1]), .aux_read_i(ev_q[2]), .active_entry_i(ev_q[3]),
        .motion_detect_mode_pin_i(lv_q[0]), .buffer_watermark_flag_i(lv_q[1]),
        .buffer_overflow_flag_i(lv_q[2]), .buffer_gate_err_i(lv_q[3]),
        .buffer_full_i(lv_q[4]), .outside_event_active_i(lv_q[5]),
        .outside_limits_source_read_i(ev_q[4]), .inside_limits_flag_i(lv_q[6]),
        .orientation_change_flag_i(lv_q[7]), .auto_sleep_flag_i(lv_q[8]),
        .irq_pin_one_o(pin1), .irq_pin_two_o(pin2), .irq_o(irq));

    aisf_host_model aisf_host_model_i (
        .core_clk_i(core_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready));

    // Clock generation
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Read notes its expectation; error flag sits above the data
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
        exp_q.push_back({e, d});
        aisf_host_model_i.bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aisf_host_model_i.bus(1'b1, a, d);
    endtask : wr

    // One-cycle event pulse
    task automatic ev(input int k);
        @(posedge core_clk_i);
        ev_q[k] <= 1'b1;
        @(posedge core_clk_i);
        ev_q <= 5'h00;
    endtask : ev

    task automatic lv(input int k, input logic v);
        @(posedge core_clk_i);
        lv_q[k] <= v;
        repeat (3) @(posedge core_clk_i);
    endtask : lv

    // Counts cycles of pin one high over a fixed window
    task automatic count_pin();
        n = 0;
        repeat (100) begin
            @(negedge core_clk_i);
            n += int'(pin1);
        end
    endtask : count_pin

    // Read monitor: compares each completed read with the oldest note
    always @(posedge core_clk_i) begin
        if (psel && penable && !pwrite && pready) begin
            chk("apb read", exp_q.pop_front(), {pslverr, prdata});
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        finish_test();
    end

    initial begin
        srst_i = 1'b1;
        ev_q = 5'h00;
        lv_q = 9'h000;
        seed = 32'h00000031;
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(ADDR_STATUS, 32'h01);
        wr(ADDR_STATUS, 32'hFF);
        rd(ADDR_STATUS, 32'h00);
        rd(8'h20, 32'h0, 1'b1);
        ev(0);
        rd(ADDR_STATUS, 32'h80);
        @(negedge core_clk_i);
        chk("pin one", 1, pin1);
        ev(1);
        rd(ADDR_STATUS, 32'h00);
        @(negedge core_clk_i);
        chk("pin one", 0, pin1);
        ev(0);
        ev(2);
        rd(ADDR_STATUS, 32'h00);
        ev(0);
        ev(0);
        rd(ADDR_STATUS, 32'hC0);
        rd(ADDR_STATUS, 32'h80);
        ev(1);
        ev(0);
        rd(ADDR_STATUS, 32'h80);
        ev(1);
        // Interrupt mask, sticky bits and output
        wr(ADDR_IRQ_MASK, rnd());
        rd(ADDR_IRQ_MASK, {24'h0, seed[7:0]});
        wr(ADDR_IRQ_MASK, 32'h0);
        @(negedge core_clk_i);
        chk("irq masked", 0, irq);
        wr(ADDR_IRQ_MASK, 32'h40);
        @(negedge core_clk_i);
        chk("irq raised", 1, irq);
        wr(ADDR_IRQ_STAT, 32'h40);
        @(negedge core_clk_i);
        chk("irq cleared", 0, irq);
        rd(ADDR_IRQ_STAT, 32'h80);
        // Mirrored sources from random levels
        rm = rnd();
        @(posedge core_clk_i);
        lv_q[8:6] <= rm[2:0];
        repeat (3) @(posedge core_clk_i);
        rd(ADDR_STATUS, {28'h0, rm[0], rm[1], rm[2], 1'b0});
        lv_q[8:6] <= 3'h0;
        lv(5, 1'b1);
        rd(ADDR_STATUS, 32'h10);
        lv(5, 1'b0);
        rd(ADDR_STATUS, 32'h00);
        wr(ADDR_CTRL, 32'h04);
        lv(5, 1'b1);
        lv(5, 1'b0);
        rd(ADDR_STATUS, 32'h10);
        ev(4);
        rd(ADDR_STATUS, 32'h00);
        lv(2, 1'b1);
        rd(ADDR_STATUS, 32'h00);
        lv(2, 1'b0);
        // Pulse mode on pin one
        lv(0, 1'b1);
        ev(0);
        count_pin();
        chk("pulse width", PC, n);
        ev(0);
        repeat (5) @(posedge core_clk_i);
        ev(3);
        count_pin();
        chk("pulse cut", 1, n <= 2);
        ev(1);
        lv(0, 1'b0);
        // Buffer enabled modes
        wr(ADDR_CTRL, 32'h31);
        ev(0);
        ev(0);
        rd(ADDR_STATUS, 32'h00);
        lv(1, 1'b1);
        rd(ADDR_STATUS, 32'h20);
        lv(1, 1'b0);
        lv(3, 1'b1);
        rd(ADDR_STATUS, 32'h20);
        lv(3, 1'b0);
        lv(4, 1'b1);
        @(negedge core_clk_i);
        chk("pin two", 1, pin2);
        lv(4, 1'b0);
        wr(ADDR_CTRL, 32'h02);
        lv(1, 1'b1);
        rd(ADDR_STATUS, 32'h00);
        lv(2, 1'b1);
        rd(ADDR_STATUS, 32'h20);
        rd(ADDR_BUF_STATE, 32'h03);
        rd(ADDR_CTRL, 32'h02);
        lv_q[2:1] <= 2'h0;
        // Buffer full routed to pin one
        wr(ADDR_CTRL, 32'h11);
        lv(4, 1'b1);
        @(negedge core_clk_i);
        chk("pin one", 1, pin1);
        lv(4, 1'b0);
        // Data-ready routed to pin two
        wr(ADDR_CTRL, 32'h08);
        ev(0);
        repeat (2) @(negedge core_clk_i);
        chk("pin two", 1, pin2);
        repeat (4) @(posedge core_clk_i);
        finish_test();
    end
endmodule : test_accel_interrupt_status_flags
